// File: hw/pct_byte_reg.sv
// Purpose: one software-written configuration byte with its own write strobe
// Assumes: write strobe already qualified by decode and byte enable
// Notes:   holds its value while the clock enable is low
`default_nettype none

module pct_byte_reg
   import pct_pkg::*;
#(
   parameter logic [7:0] RESET_VALUE = 8'h00
)
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       clkEn,
   input  wire logic       writeEn,
   input  wire logic [7:0] writeData,
   output logic      [7:0] value
);

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         value <= RESET_VALUE;
      end
      else if (clkEn && writeEn)
      begin
         value <= writeData;
      end
   end

endmodule

`default_nettype wire

// File: hw/pct_config_tail.sv
// Purpose: configuration header tail 30h..3Fh and power capability words
// Assumes: host bridge logic on mclk, one request per cycle, dword aligned
// Notes:   the control/status dword after the capability is served elsewhere
//
// Contract
// - 32-bit read-write rom base at 30h
// - byte at 34h points to power capability
// - line vector read-write, resets zero, no action
// - interrupt pin byte reads 01h, read-only
// - minimum grant byte at 3Eh, read-only
// - maximum latency byte at 3Fh, read-only
// - capability identifier byte reads 01h
// - next capability byte, end of list
// - wake from cold D3 bit reads one
// - wake from D0 bit reads zero
// - wake from D1, D2 bits read zero
// - D1 and D2 support bits read zero
// - bus clock needed bit reads zero
// - version field shows revision 1.1 or later
// - aux current code fixed, read-only
// - device init bit fixed, read-only
// - hot D3 blocks memory space and interrupts
`default_nettype none

module pct_config_tail
   import pct_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        clkEn,
   input  wire logic        cfgRead,
   input  wire logic        cfgWrite,
   input  wire logic [7:0]  cfgAddr,
   input  wire logic [3:0]  cfgByteEn,
   input  wire logic [31:0] cfgWriteData,
   input  wire logic [1:0]  powerStateField,
   output logic      [31:0] cfgReadData,
   output logic             cfgReadValid,
   output logic             cfgWriteDone,
   output logic             cfgClaim,
   output logic      [31:0] romBaseValue,
   output logic      [7:0]  irqLineVector,
   output logic             memSpaceBlocked,
   output logic             irqBlocked
);

   // ***************************************************************
   // decode
   // ***************************************************************
   logic [5:0]  dwordIndex;
   logic        takeRead;
   logic        takeWrite;
   logic        romHit;
   logic        headHit;
   logic        reservedHit;
   logic        intHit;
   logic        powerHit;
   logic        inRange;
   logic [31:0] readWord;
   logic [31:0] laneMask;

   assign dwordIndex = cfgAddr[7:2];
   assign takeRead   = clkEn && cfgRead;
   assign takeWrite  = clkEn && cfgWrite;
   // byte enables spread to bits, read only by the lane check
   assign laneMask   = {{8{cfgByteEn[3]}}, {8{cfgByteEn[2]}},
                        {8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};

   always_comb
   begin
      romHit      = 1'b0;
      headHit     = 1'b0;
      reservedHit = 1'b0;
      intHit      = 1'b0;
      powerHit    = 1'b0;
      if (dwordIndex == ROM_BASE_OFFSET[7:2])
      begin
         romHit = 1'b1;
      end
      else if (dwordIndex == CAPABILITY_HEAD_OFF[7:2])
      begin
         headHit = 1'b1;
      end
      else if (dwordIndex == RESERVED_OFFSET[7:2])
      begin
         reservedHit = 1'b1;
      end
      else if (dwordIndex == INTERRUPT_OFFSET[7:2])
      begin
         intHit = 1'b1;
      end
      else if (dwordIndex == POWER_CAPABILITY_BASE[7:2])
      begin
         powerHit = 1'b1;
      end
   end

   assign inRange = romHit || headHit || reservedHit || intHit || powerHit;

   // ***************************************************************
   // writable bytes
   // ***************************************************************
   // rom base byte lanes
   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++)
      begin : g_rom
         pct_byte_reg #(
            .RESET_VALUE (ROM_BASE_RESET[lane*8 +: 8])
         ) u_rom (
            .mclk      (mclk),
            .rst       (rst),
            .clkEn     (clkEn),
            .writeEn   (cfgWrite && romHit && cfgByteEn[lane]),
            .writeData (cfgWriteData[lane*8 +: 8]),
            .value     (romBaseValue[lane*8 +: 8])
         );
      end
   endgenerate

   pct_byte_reg #(
      .RESET_VALUE (IRQ_LINE_RESET)
   ) u_line (
      .mclk      (mclk),
      .rst       (rst),
      .clkEn     (clkEn),
      .writeEn   (cfgWrite && intHit && cfgByteEn[0]),
      .writeData (cfgWriteData[7:0]),
      .value     (irqLineVector)
   );

   // ***************************************************************
   // read data
   // ***************************************************************
   // fixed bytes are constants, so writes to them have nowhere to land
   always_comb
   begin
      readWord = 32'h0000_0000;
      if (romHit)
      begin
         readWord = romBaseValue;
      end
      else if (headHit)
      begin
         readWord = {24'h00_0000, POWER_CAPABILITY_BASE};
      end
      else if (intHit)
      begin
         // pin select beside the line vector
         readWord = {MAX_LATENCY_TIME, MIN_GRANT_VALUE, IRQ_PIN_SELECT, irqLineVector};
      end
      else if (powerHit)
      begin
         readWord = {POWER_FEATURES, NEXT_CAPABILITY, CAPABILITY_IDENTIFIER};
      end
   end

   // ***************************************************************
   // answers
   // ***************************************************************
   // configuration answers regardless of power state
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cfgReadData  <= 32'h0000_0000;
         cfgReadValid <= 1'b0;
      end
      else if (clkEn)
      begin
         cfgReadValid <= cfgRead && inRange;
         if (cfgRead && inRange)
         begin
            cfgReadData <= readWord;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cfgWriteDone <= 1'b0;
         cfgClaim     <= 1'b0;
      end
      else if (clkEn)
      begin
         cfgWriteDone <= cfgWrite && inRange;
         cfgClaim     <= (cfgRead || cfgWrite) && inRange;
      end
   end

   // ***************************************************************
   // power state effects
   // ***************************************************************
   // D1 and D2 are decoded as D0: the host must never select them
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         memSpaceBlocked <= 1'b0;
         irqBlocked      <= 1'b0;
      end
      else if (clkEn)
      begin
         memSpaceBlocked <= (powerStateField == PCT_D3_HOT);
         irqBlocked      <= (powerStateField == PCT_D3_HOT);
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   romWrite_a : assert property (
      takeWrite && romHit && (cfgByteEn == 4'hF)
      |=> romBaseValue == $past(cfgWriteData))
      else $error("rom base did not take full write");

   headRead_a : assert property (
      takeRead && headHit
      |=> cfgReadValid && (cfgReadData == {24'h00_0000, POWER_CAPABILITY_BASE}))
      else $error("capability head read wrong");

   lineStore_a : assert property (
      takeWrite && intHit && cfgByteEn[0] && !cfgRead
      ##1 clkEn && cfgRead && intHit
      |=> cfgReadData[7:0] == $past(cfgWriteData[7:0], 2))
      else $error("line vector not read back");

   pinRead_a : assert property (
      takeRead && intHit
      |=> cfgReadData[15:8] == IRQ_PIN_SELECT)
      else $error("interrupt pin byte wrong");

   grantLatency_a : assert property (
      takeRead && intHit
      |=> (cfgReadData[23:16] == MIN_GRANT_VALUE)
          && (cfgReadData[31:24] == MAX_LATENCY_TIME))
      else $error("grant or latency byte wrong");

   idRead_a : assert property (
      takeRead && powerHit
      |=> cfgReadValid && (cfgReadData[7:0] == 8'h01)
          && (cfgReadData[15:8] == NEXT_CAPABILITY))
      else $error("capability identifier word wrong");

   wakeBits_a : assert property (
      takeRead && powerHit
      |=> cfgReadData[WAKE_COLD_BIT] && !cfgReadData[WAKE_ZERO_BIT]
          && !cfgReadData[WAKE_ONE_BIT] && !cfgReadData[WAKE_TWO_BIT]
          && !cfgReadData[STATE_ONE_BIT] && !cfgReadData[STATE_TWO_BIT])
      else $error("wake support bits wrong");

   featureTail_a : assert property (
      takeRead && powerHit
      |=> !cfgReadData[BUS_CLOCK_BIT] && (cfgReadData[18:16] >= 3'h2)
          && (cfgReadData[31:16] == POWER_FEATURES))
      else $error("capability feature tail wrong");

   hotBlock_a : assert property (
      clkEn && (powerStateField == PCT_D3_HOT)
      |=> irqBlocked && memSpaceBlocked)
      else $error("hot D3 did not block");

   hotRelease_a : assert property (
      clkEn && (powerStateField == PCT_D0)
      |=> !irqBlocked && !memSpaceBlocked)
      else $error("D0 left blocks set");

   reservedRead_a : assert property (
      takeRead && reservedHit
      |=> cfgReadValid && (cfgReadData == 32'h0000_0000))
      else $error("reserved dword not zero");

   readOnlyKeep_a : assert property (
      takeWrite && intHit && !cfgByteEn[0]
      |=> $stable(irqLineVector))
      else $error("read-only lane write altered line");

   lineHold_a : assert property (
      !(takeWrite && intHit && cfgByteEn[0])
      |=> $stable(irqLineVector))
      else $error("line vector changed without write");

   romHold_a : assert property (
      !(takeWrite && romHit)
      |=> $stable(romBaseValue))
      else $error("rom base changed without write");

   romLanes_a : assert property (
      takeWrite && romHit
      |=> romBaseValue == (($past(cfgWriteData) & $past(laneMask))
                          | ($past(romBaseValue) & ~$past(laneMask))))
      else $error("rom base lanes wrong");

   writeDone_a : assert property (
      takeWrite && inRange
      |=> cfgWriteDone && cfgClaim)
      else $error("claimed write not answered");

   readClaim_a : assert property (
      takeRead && inRange
      |=> cfgReadValid && cfgClaim)
      else $error("claimed read not answered");

   noClaim_a : assert property (
      clkEn && !((cfgRead || cfgWrite) && inRange)
      |=> !cfgClaim && !cfgReadValid && !cfgWriteDone)
      else $error("unclaimed cycle pulsed");

   readHold_a : assert property (
      !(takeRead && inRange)
      |=> $stable(cfgReadData))
      else $error("read data moved without read");

   freezeAnswer_a : assert property (
      !clkEn
      |=> $stable(cfgReadValid) && $stable(cfgWriteDone) && $stable(cfgClaim))
      else $error("answer moved while frozen");

   freezeBlock_a : assert property (
      !clkEn
      |=> $stable(irqBlocked) && $stable(memSpaceBlocked))
      else $error("blocks moved while frozen");

endmodule

`default_nettype wire

// File: hw/pct_pkg.sv
// Purpose: constants for the configuration header tail and power capability
// Assumes: configuration space of 256 bytes, dword accesses with byte enables
// Notes:   implementation-specific codes are plain defaults, change per product
`default_nettype none

package pct_pkg;

   // ***************************************************************
   // offsets in configuration space
   // ***************************************************************
   localparam logic [7:0] ROM_BASE_OFFSET     = 8'h30;
   localparam logic [7:0] CAPABILITY_HEAD_OFF = 8'h34;
   localparam logic [7:0] RESERVED_OFFSET     = 8'h38;
   localparam logic [7:0] INTERRUPT_OFFSET    = 8'h3C;
   localparam logic [7:0] MIN_GRANT_OFFSET    = 8'h3E;
   localparam logic [7:0] MAX_LATENCY_OFFSET  = 8'h3F;
   localparam logic [7:0] POWER_CAPABILITY_BASE = 8'h80;

   // ***************************************************************
   // reset and fixed values
   // ***************************************************************
   localparam logic [31:0] ROM_BASE_RESET     = 32'h0000_0000;
   localparam logic [7:0]  IRQ_LINE_RESET     = 8'h00;
   localparam logic [7:0]  IRQ_PIN_SELECT     = 8'h01;
   localparam logic [7:0]  MIN_GRANT_VALUE    = 8'h00;
   localparam logic [7:0]  MAX_LATENCY_TIME   = 8'h00;
   localparam logic [7:0]  CAPABILITY_IDENTIFIER = 8'h01;
   // end of list; set to the following capability when one is fitted
   localparam logic [7:0]  NEXT_CAPABILITY    = 8'h00;

   // ***************************************************************
   // power capability features word
   // ***************************************************************
   localparam logic [4:0] WAKE_STATE_SUPPORT_MASK = 5'h18;
   localparam logic       STATE_TWO_SUPPORT    = 1'b0;
   localparam logic       STATE_ONE_SUPPORT    = 1'b0;
   localparam logic [2:0] AUX_CURRENT_CODE     = 3'h0;
   localparam logic       DEVICE_INIT_NEEDED   = 1'b0;
   localparam logic       FEATURE_RESERVED     = 1'b0;
   localparam logic       WAKE_NEEDS_BUS_CLOCK = 1'b0;
   localparam logic [2:0] POWER_SPEC_VERSION   = 3'h2;
   localparam logic [15:0] POWER_FEATURES = {WAKE_STATE_SUPPORT_MASK,
      STATE_TWO_SUPPORT, STATE_ONE_SUPPORT, AUX_CURRENT_CODE, DEVICE_INIT_NEEDED,
      FEATURE_RESERVED, WAKE_NEEDS_BUS_CLOCK, POWER_SPEC_VERSION};

   // field positions inside the power capability dword
   localparam int WAKE_COLD_BIT   = 31;
   localparam int WAKE_HOT_BIT    = 30;
   localparam int WAKE_TWO_BIT    = 29;
   localparam int WAKE_ONE_BIT    = 28;
   localparam int WAKE_ZERO_BIT   = 27;
   localparam int STATE_TWO_BIT   = 26;
   localparam int STATE_ONE_BIT   = 25;
   localparam int BUS_CLOCK_BIT   = 19;

   // ***************************************************************
   // power state field encoding
   // ***************************************************************
   typedef enum logic [1:0] {
      PCT_D0     = 2'h0,
      PCT_D1     = 2'h1,
      PCT_D2     = 2'h2,
      PCT_D3_HOT = 2'h3
   } pct_power_state_t;

endpackage

`default_nettype wire

// File: testbench/pct_config_tail_bench.sv
// Purpose: self-checking bench for the header tail and power capability
// Assumes: 100 MHz mclk, inputs move 1 ns after the rising edge
// Notes:   clock enable dropped once, to show a frozen write is lost
`default_nettype none

module pct_config_tail_bench
   import pct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  powerStateField = 2'h0;
   logic        clkEn = 1'b1;
   logic        cfgRead, cfgWrite, cfgReadValid, cfgWriteDone, cfgClaim;
   logic        memSpaceBlocked, irqBlocked;
   logic [7:0]  cfgAddr, irqLineVector;
   logic [3:0]  cfgByteEn;
   logic [31:0] cfgWriteData, cfgReadData, romBaseValue;
   int          fails = 0;
   int          checks = 0;

   always #5 mclk = ~mclk;

   pct_config_tail i_pct_config_tail
   (
      .mclk(mclk), .rst(rst), .clkEn(clkEn), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
      .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
      .powerStateField(powerStateField), .cfgReadData(cfgReadData),
      .cfgReadValid(cfgReadValid), .cfgWriteDone(cfgWriteDone), .cfgClaim(cfgClaim),
      .romBaseValue(romBaseValue), .irqLineVector(irqLineVector),
      .memSpaceBlocked(memSpaceBlocked), .irqBlocked(irqBlocked)
   );

   pct_host_model i_pct_host_model
   (
      .mclk(mclk), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
      .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
      .cfgReadValid(cfgReadValid), .cfgWriteDone(cfgWriteDone), .cfgClaim(cfgClaim)
   );

   // ***************************************************************
   // compares and bus helpers
   // ***************************************************************
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        ok;
      i_pct_host_model.access(1'b0, a, 4'h0, 32'h0000_0000, q, ok);
      chk1(ok, 1'b1, "read answered");
      chk32(q, exp, "read data");
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      logic [31:0] q;
      logic        ok;
      i_pct_host_model.access(1'b1, a, be, d, q, ok);
      chk1(ok, 1'b1, "write answered");
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset;
      rd(ROM_BASE_OFFSET, ROM_BASE_RESET);
      rd(INTERRUPT_OFFSET, {MAX_LATENCY_TIME, MIN_GRANT_VALUE, 8'h01, 8'h00});
      rd(CAPABILITY_HEAD_OFF, {24'h0, POWER_CAPABILITY_BASE});
      rd(RESERVED_OFFSET, 32'h0000_0000);
      $display("t_reset done");
   endtask

   task automatic t_power_words;
      logic [31:0] q;
      logic        ok;
      i_pct_host_model.access(1'b0, POWER_CAPABILITY_BASE, 4'h0, 32'h0, q, ok);
      chk1(ok, 1'b1, "cap read answered");
      chk32({24'h0, q[7:0]}, 32'h0000_0001, "cap id");
      chk32({24'h0, q[15:8]}, {24'h0, NEXT_CAPABILITY}, "next pointer");
      chk1(q[31], 1'b1, "wake cold");
      chk1(q[27], 1'b0, "wake d0");
      chk1(q[29] | q[28], 1'b0, "wake d1 d2");
      chk1(q[26] | q[25], 1'b0, "d1 d2 support");
      chk1(q[19], 1'b0, "bus clock");
      chk1(q[18:16] >= 3'h2, 1'b1, "version");
      chk32({29'h0, q[24:22]}, {29'h0, AUX_CURRENT_CODE}, "aux current");
      chk1(q[21], DEVICE_INIT_NEEDED, "init bit");
      chk1(q[20], 1'b0, "reserved bit");
      // read-only words must survive an all-ones write
      wr(POWER_CAPABILITY_BASE, 4'hF, 32'hFFFF_FFFF);
      rd(POWER_CAPABILITY_BASE, {POWER_FEATURES, NEXT_CAPABILITY, 8'h01});
      $display("t_power_words done");
   endtask

   task automatic t_rom;
      wr(ROM_BASE_OFFSET, 4'hF, 32'hFFFF_FFFF);
      wr(ROM_BASE_OFFSET, 4'h5, 32'h1234_5678);
      wr(ROM_BASE_OFFSET, 4'h0, 32'hA5A5_5A5A);
      rd(ROM_BASE_OFFSET, 32'hFF34_FF78);
      chk32(romBaseValue, 32'hFF34_FF78, "rom port");
      $display("t_rom done");
   endtask

   task automatic t_line;
      logic [31:0] q;
      logic        okW;
      logic        okR;
      wr(INTERRUPT_OFFSET, 4'hF, 32'hFFFF_FFAB);
      rd(INTERRUPT_OFFSET, {MAX_LATENCY_TIME, MIN_GRANT_VALUE, 8'h01, 8'hAB});
      chk32({24'h0, irqLineVector}, 32'h0000_00AB, "line port");
      // lane 0 off: the line must keep its value
      wr(INTERRUPT_OFFSET, 4'hE, 32'h1122_3344);
      rd(INTERRUPT_OFFSET, {MAX_LATENCY_TIME, MIN_GRANT_VALUE, 8'h01, 8'hAB});
      // read on the edge right after the write
      i_pct_host_model.write_read(INTERRUPT_OFFSET, 4'h1, 32'h0000_005C, q, okW, okR);
      chk1(okW, 1'b1, "line write answered");
      chk1(okR, 1'b1, "line read answered");
      chk32(q, {MAX_LATENCY_TIME, MIN_GRANT_VALUE, 8'h01, 8'h5C}, "line back to back");
      $display("t_line done");
   endtask

   task automatic t_readonly;
      logic [31:0] q;
      logic        ok;
      wr(CAPABILITY_HEAD_OFF, 4'hF, 32'hFFFF_FFFF);
      wr(RESERVED_OFFSET, 4'hF, 32'hFFFF_FFFF);
      rd(CAPABILITY_HEAD_OFF, {24'h0, POWER_CAPABILITY_BASE});
      rd(RESERVED_OFFSET, 32'h0000_0000);
      // the control/status dword belongs to another block
      i_pct_host_model.access(1'b1, 8'h84, 4'hF, 32'hFFFF_FFFF, q, ok);
      chk1(ok, 1'b0, "unclaimed write");
      $display("t_readonly done");
   endtask

   task automatic t_hot_d3;
      @(posedge mclk);
      #1;
      powerStateField = 2'h3;
      rd(CAPABILITY_HEAD_OFF, {24'h0, POWER_CAPABILITY_BASE});
      chk1(memSpaceBlocked, 1'b1, "mem blocked");
      chk1(irqBlocked, 1'b1, "irq blocked");
      powerStateField = 2'h0;
      repeat (2) @(posedge mclk);
      #1;
      chk1(memSpaceBlocked | irqBlocked, 1'b0, "unblocked");
      $display("t_hot_d3 done");
   endtask

   task automatic t_freeze;
      logic [31:0] q;
      logic        ok;
      @(posedge mclk);
      #1;
      clkEn = 1'b0;
      i_pct_host_model.access(1'b1, ROM_BASE_OFFSET, 4'hF, 32'h0BAD_F00D, q, ok);
      chk1(ok, 1'b0, "frozen write answered");
      chk32(romBaseValue, 32'hFF34_FF78, "frozen rom port");
      clkEn = 1'b1;
      rd(ROM_BASE_OFFSET, 32'hFF34_FF78);
      $display("t_freeze done");
   endtask

   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_reset();
      t_power_words();
      t_rom();
      t_line();
      t_readonly();
      t_hot_d3();
      t_freeze();
      final_report();
   end

   // well above the roughly 70 cycles the tests need
   initial
   begin
      repeat (3000) @(posedge mclk);
      fails++;
      final_report();
   end

endmodule

`default_nettype wire

// File: testbench/pct_host_model.sv
// Purpose: host bridge model issuing configuration reads and writes
// Assumes: one request in flight, answer pulses come one cycle later
// Notes:   released lines show inverted values so stale data is not trusted
`default_nettype none

module pct_host_model
(
   input  wire logic        mclk,
   output logic             cfgRead,
   output logic             cfgWrite,
   output logic      [7:0]  cfgAddr,
   output logic      [3:0]  cfgByteEn,
   output logic      [31:0] cfgWriteData,
   input  wire logic [31:0] cfgReadData,
   input  wire logic        cfgReadValid,
   input  wire logic        cfgWriteDone,
   input  wire logic        cfgClaim
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      cfgRead = 1'b0;
      cfgWrite = 1'b0;
      cfgAddr = 8'h00;
      cfgByteEn = 4'h0;
      cfgWriteData = 32'h0000_0000;
   end

   // ***************************************************************
   // one access, taken at one edge, answered at the next
   // ***************************************************************
   task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
      @(posedge mclk);
      #1;
      cfgRead = ~wr;
      cfgWrite = wr;
      cfgAddr = a;
      cfgByteEn = be;
      cfgWriteData = d;
      @(posedge mclk);
      #1;
      cfgRead = 1'b0;
      cfgWrite = 1'b0;
      cfgAddr = ~a;
      cfgByteEn = ~be;
      cfgWriteData = ~d;
      q = cfgReadData;
      ok = (wr ? cfgWriteDone : cfgReadValid) & cfgClaim;
   endtask

   // ***************************************************************
   // write, then a read of the same dword on the very next edge
   // ***************************************************************
   task automatic write_read(input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q, output logic okW, output logic okR);
      @(posedge mclk);
      #1;
      cfgRead = 1'b0;
      cfgWrite = 1'b1;
      cfgAddr = a;
      cfgByteEn = be;
      cfgWriteData = d;
      @(posedge mclk);
      #1;
      cfgWrite = 1'b0;
      cfgRead = 1'b1;
      okW = cfgWriteDone & cfgClaim;
      @(posedge mclk);
      #1;
      cfgRead = 1'b0;
      cfgAddr = ~a;
      cfgByteEn = ~be;
      cfgWriteData = ~d;
      q = cfgReadData;
      okR = cfgReadValid & cfgClaim;
   endtask

endmodule

`default_nettype wire
